/* File: rtl/pdp_defs.vh */
// offsets, field positions, reset values and timing counts of the debug port physical layer
`ifndef PDP_DEFS_VH
`define PDP_DEFS_VH
// register byte offsets on the ahb-lite slave
`define PDP_OFS_CTRL 8'h00
`define PDP_OFS_GUARD 8'h04
`define PDP_OFS_TXDATA 8'h08
`define PDP_OFS_RXDATA 8'h0c
`define PDP_OFS_STATUS 8'h10
// control fields
`define PDP_CTRL_TXREQ 0
`define PDP_CTRL_SCANDIS 1
// status fields
`define PDP_ST_ACTIVE 0
`define PDP_ST_RSTOFF 1
`define PDP_ST_PERR 2
`define PDP_ST_FERR 3
`define PDP_ST_BRK 4
`define PDP_ST_COL 5
`define PDP_ST_COMM 6
`define PDP_ST_DEVRST 7
`define PDP_ST_TXMODE 8
// guard reset value and guard floor
`define PDP_GUARD_RST 8'h80
`define PDP_GUARD_MIN 8'h02
// frame and character sizes, activation clock count
`define PDP_FRAME_BITS 4'hc
`define PDP_CHAR_BITS 4'hc
`define PDP_ACT_CLKS 5'h10
// timing, as printed, and the clock rate
`define PDP_HCLK_NS 20
`define PDP_RST_MIN_NS 2500
`define PDP_ACT_WIN_NS 100000
`define PDP_INACT_NS 100000
// reset pulse is a least time: round up; windows are longest times: round down
`define PDP_RST_MIN_CYC ((`PDP_RST_MIN_NS + `PDP_HCLK_NS - 1) / `PDP_HCLK_NS)
`define PDP_ACT_WIN_CYC (`PDP_ACT_WIN_NS / `PDP_HCLK_NS)
`define PDP_INACT_CYC (`PDP_INACT_NS / `PDP_HCLK_NS)
// tap instruction that selects the 9-bit communication register
`define PDP_IR_COMM 4'h7
`define PDP_IR_CAPT 4'h1
`endif

/* File: rtl/pdp_top.v */
// two-wire programming and debug port physical layer with scan-path access and ahb-lite registers
// Function
// - data line high past reset minimum pulse disables the reset function of clock pin
// - first debug clock within 100us of reset disable, else sequence restarts
// - on enable the reset pin level is sampled into the device reset hold
// - debug clock slower than 10kHz disables port and restores reset function
// - frame: low start, eight data, even parity, two high stop bits
// - break is 12+ low bit times, idle is 12+ high bit times
// - after activation the port receives, waiting for a start bit
// - sender changes data on falling clock, receiver samples on rising clock
// - in transmit mode idle high bits fill gaps between frames
// - collision while sending releases the driver and waits in receive for break
// - received parity not matching even parity of data flags parity error
// - low stop bit flags frame error; byte passed only when clean
// - break while sending is a collision; break while receiving is a break
// - receive to transmit inserts configurable idle bits, at least two, default 128
// - driver active only in the cycle a bit changes; keeper holds otherwise; the first bit after the turn to transmit is driven too
// - bit held two or more cycles is compared with the line; mismatch is collision
// - scan path usable only with enable fuse set and scan-disable bit clear
// - comm instruction selects 9-bit register: capture, shift, update to controller
// - scan frame is eight data bits then parity, no start or stop
// - scan data shifted lsb first with even parity
//
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "pdp_defs.vh"
module pdp_top #(
   parameter ACT_WIN_CYC = `PDP_ACT_WIN_CYC,
   parameter INACT_CYC = `PDP_INACT_CYC,
   parameter RST_MIN_CYC = `PDP_RST_MIN_CYC
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire debug_clock_line,
   input wire debug_data_line_in,
   output wire debug_data_line_out,
   output wire debug_data_line_oe_n,
   input wire reset_fuse_off,
   input wire scan_port_enable_fuse,
   output wire reset_function_off,
   output wire device_reset_hold,
   output wire port_active,
   input wire tck,
   input wire tms,
   input wire tdi,
   output wire tdo
);
   // enable sequence states
   localparam EN_OFF = 2'b00;
   localparam EN_WAIT = 2'b01;
   localparam EN_CNT = 2'b10;
   localparam EN_ON = 2'b11;
   // tap states
   localparam T_TLR = 4'h0, T_RTI = 4'h1, T_SDR = 4'h2, T_CDR = 4'h3, T_SHDR = 4'h4, T_E1DR = 4'h5;
   localparam T_PDR = 4'h6, T_E2DR = 4'h7, T_UDR = 4'h8, T_SIR = 4'h9, T_CIR = 4'ha, T_SHIR = 4'hb;
   localparam T_E1IR = 4'hc, T_PIR = 4'hd, T_E2IR = 4'he, T_UIR = 4'hf;

   // two-flop synchronisers for the debug clock, data and scan pins; s1 feeds only s2
   reg [4:0] s1_q, s2_q, s3_q;
   wire dclk = s2_q[0];
   wire ddat = s2_q[1];
   wire tck_s = s2_q[2];
   wire tms_s = s2_q[3];
   wire tdi_s = s2_q[4];
   wire d_rise = dclk & ~s3_q[0];
   wire d_fall = ~dclk & s3_q[0];
   wire t_rise = tck_s & ~s3_q[2];
   wire t_fall = ~tck_s & s3_q[2];
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= 5'h1f;
         s2_q <= 5'h1f;
         s3_q <= 5'h1f;
      end else begin
         s1_q <= {tdi, tms, tck, debug_data_line_in, debug_clock_line};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // registers and shared flags
   reg txreq_q, scandis_q, pend_q, rxv_q, perr_q, ferr_q, brk_q, col_q;
   reg [7:0] guard_q, txd_q, rxd_q;
   reg take_q, rxld_q, perr_p_q, ferr_p_q, brk_p_q, col_p_q;
   reg jrx_q, jok_q, jtake_q;
   reg [7:0] rxbyte_q, jbyte_q;
   reg [1:0] en_q;
   reg dev_rst_q, txmode_q;
   reg [31:0] tmr_q;
   reg [4:0] act_q;

   // enable, activation and inactivity supervision
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_q <= EN_OFF;
         tmr_q <= 32'h0;
         act_q <= 5'h0;
         dev_rst_q <= 1'b0;
      end else begin
         case (en_q)
            EN_OFF: begin
               // data held high long enough switches off the reset function
               tmr_q <= ddat ? tmr_q + 32'h1 : 32'h0;
               if (ddat && tmr_q >= RST_MIN_CYC - 1) begin
                  en_q <= EN_WAIT;
                  tmr_q <= 32'h0;
               end
            end
            EN_WAIT: begin
               tmr_q <= tmr_q + 32'h1;
               if (!ddat || tmr_q >= ACT_WIN_CYC - 1) begin
                  en_q <= EN_OFF;
                  tmr_q <= 32'h0;
               end else if (d_rise) begin
                  en_q <= EN_CNT;
                  act_q <= 5'h1;
                  tmr_q <= 32'h0;
               end
            end
            EN_CNT: begin
               tmr_q <= d_rise ? 32'h0 : tmr_q + 32'h1;
               if (!ddat || tmr_q >= INACT_CYC - 1) begin
                  en_q <= EN_OFF;
                  tmr_q <= 32'h0;
               end else if (d_rise) begin
                  act_q <= act_q + 5'h1;
                  if (act_q == `PDP_ACT_CLKS - 5'h1) begin
                     en_q <= EN_ON;
                     dev_rst_q <= ~dclk;
                  end
               end
            end
            EN_ON: begin
               // a stalled debug clock ends the session
               tmr_q <= d_rise ? 32'h0 : tmr_q + 32'h1;
               if (tmr_q >= INACT_CYC - 1) begin
                  en_q <= EN_OFF;
                  tmr_q <= 32'h0;
                  dev_rst_q <= 1'b0;
               end
            end
            default: en_q <= EN_OFF;
         endcase
      end
   end
   wire on = (en_q == EN_ON);
   assign port_active = on;
   assign reset_function_off = reset_fuse_off | (en_q != EN_OFF);
   assign device_reset_hold = dev_rst_q;

   // two-wire transmit and receive engine
   reg [10:0] tsh_q;
   reg [3:0] tbits_q, rcnt_q, low_q;
   reg [7:0] gcnt_q;
   reg out_q, drv_q, fresh_q, rxbusy_q, armed_q, waitbrk_q;
   reg [9:0] rsh_q;
   reg nb;
   always @* begin
      // next outgoing bit: guard idle, frame bit, or gap-filling idle
      nb = 1'b1;
      if (gcnt_q != 8'h0)
         nb = 1'b1;
      else if (tbits_q != 4'h0)
         nb = tsh_q[0];
      else if (pend_q && !take_q)
         nb = 1'b0;
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         txmode_q <= 1'b0;
         tsh_q <= 11'h7ff;
         tbits_q <= 4'h0;
         gcnt_q <= 8'h0;
         out_q <= 1'b1;
         drv_q <= 1'b0;
         fresh_q <= 1'b0;
         rxbusy_q <= 1'b0;
         armed_q <= 1'b0;
         waitbrk_q <= 1'b0;
         rcnt_q <= 4'h0;
         low_q <= 4'h0;
         rsh_q <= 10'h0;
         take_q <= 1'b0;
         rxld_q <= 1'b0;
         rxbyte_q <= 8'h0;
         perr_p_q <= 1'b0;
         ferr_p_q <= 1'b0;
         brk_p_q <= 1'b0;
         col_p_q <= 1'b0;
      end else begin
         take_q <= 1'b0;
         rxld_q <= 1'b0;
         perr_p_q <= 1'b0;
         ferr_p_q <= 1'b0;
         brk_p_q <= 1'b0;
         col_p_q <= 1'b0;
         // scan results land even with the two-wire side off; a good two-wire byte or parity error below overrides them
         if (jrx_q) begin
            rxld_q <= jok_q;
            perr_p_q <= ~jok_q;
            rxbyte_q <= jbyte_q;
         end
         if (jtake_q)
            take_q <= 1'b1;
         if (!on) begin
            // inactive port starts over in receive with the line released
            txmode_q <= 1'b0;
            tbits_q <= 4'h0;
            gcnt_q <= 8'h0;
            drv_q <= 1'b0;
            out_q <= 1'b1;
            rxbusy_q <= 1'b0;
            armed_q <= 1'b0;
            waitbrk_q <= 1'b0;
            low_q <= 4'h0;
         end else if (d_fall) begin
            // outputs change only on the falling debug clock edge
            if (!txmode_q) begin
               if (txreq_q && !rxbusy_q && !waitbrk_q) begin
                  txmode_q <= 1'b1;
                  gcnt_q <= (guard_q < `PDP_GUARD_MIN) ? `PDP_GUARD_MIN : guard_q;
                  fresh_q <= 1'b1;
               end
            end else if (!txreq_q && tbits_q == 4'h0 && gcnt_q == 8'h0) begin
               txmode_q <= 1'b0;
               drv_q <= 1'b0;
            end else begin
               if (gcnt_q != 8'h0) begin
                  gcnt_q <= gcnt_q - 8'h1;
               end else if (tbits_q != 4'h0) begin
                  tsh_q <= {1'b1, tsh_q[10:1]};
                  tbits_q <= tbits_q - 4'h1;
               end else if (pend_q && !take_q) begin
                  // stop, stop, parity, data lsb first; start goes out now
                  tsh_q <= {2'b11, ^txd_q, txd_q};
                  tbits_q <= `PDP_FRAME_BITS - 4'h1;
                  take_q <= 1'b1;
               end
               // drive on a change and on the first bit after entering transmit; the keeper holds steady bits
               drv_q <= fresh_q | (nb != out_q);
               out_q <= nb;
               fresh_q <= 1'b0;
            end
         end else if (d_rise) begin
            // inputs are sampled on the rising debug clock edge
            if (txmode_q) begin
               if (!fresh_q && !drv_q && ddat != out_q) begin
                  // a break from the programmer lands here as a collision
                  txmode_q <= 1'b0;
                  tbits_q <= 4'h0;
                  gcnt_q <= 8'h0;
                  waitbrk_q <= 1'b1;
                  col_p_q <= 1'b1;
                  armed_q <= 1'b0;
                  low_q <= ddat ? 4'h0 : 4'h1;
               end
            end else begin
               low_q <= ddat ? 4'h0 : ((low_q == `PDP_CHAR_BITS) ? low_q : low_q + 4'h1);
               if (ddat)
                  armed_q <= 1'b1;
               if (!ddat && low_q == `PDP_CHAR_BITS - 4'h1) begin
                  brk_p_q <= 1'b1;
                  waitbrk_q <= 1'b0;
                  rxbusy_q <= 1'b0;
                  armed_q <= 1'b0;
               end else if (rxbusy_q) begin
                  rcnt_q <= rcnt_q + 4'h1;
                  rsh_q <= {ddat, rsh_q[9:1]};
                  if (rcnt_q == 4'ha) begin
                     rxbusy_q <= 1'b0;
                     armed_q <= ddat;
                     if (!rsh_q[9] || !ddat)
                        ferr_p_q <= 1'b1;
                     else if (^rsh_q[8:0])
                        perr_p_q <= 1'b1;
                     else begin
                        rxld_q <= 1'b1;
                        rxbyte_q <= rsh_q[7:0];
                     end
                  end
               end else if (armed_q && !ddat && !waitbrk_q) begin
                  rxbusy_q <= 1'b1;
                  rcnt_q <= 4'h0;
               end
            end
         end
      end
   end
   assign debug_data_line_out = out_q;
   assign debug_data_line_oe_n = ~drv_q;

   // scan tap with the 9-bit communication register
   reg [3:0] tap_q, ir_q, irsh_q;
   reg [8:0] dr_q;
   reg byp_q, tdo_q;
   reg [3:0] tap_d;
   wire scan_ok = scan_port_enable_fuse & ~scandis_q;
   wire comm = (ir_q == `PDP_IR_COMM);
   always @* begin
      case (tap_q)
         T_TLR: tap_d = tms_s ? T_TLR : T_RTI;
         T_RTI: tap_d = tms_s ? T_SDR : T_RTI;
         T_SDR: tap_d = tms_s ? T_SIR : T_CDR;
         T_CDR: tap_d = tms_s ? T_E1DR : T_SHDR;
         T_SHDR: tap_d = tms_s ? T_E1DR : T_SHDR;
         T_E1DR: tap_d = tms_s ? T_UDR : T_PDR;
         T_PDR: tap_d = tms_s ? T_E2DR : T_PDR;
         T_E2DR: tap_d = tms_s ? T_UDR : T_SHDR;
         T_UDR: tap_d = tms_s ? T_SDR : T_RTI;
         T_SIR: tap_d = tms_s ? T_TLR : T_CIR;
         T_CIR: tap_d = tms_s ? T_E1IR : T_SHIR;
         T_SHIR: tap_d = tms_s ? T_E1IR : T_SHIR;
         T_E1IR: tap_d = tms_s ? T_UIR : T_PIR;
         T_PIR: tap_d = tms_s ? T_E2IR : T_PIR;
         T_E2IR: tap_d = tms_s ? T_UIR : T_SHIR;
         T_UIR: tap_d = tms_s ? T_SDR : T_RTI;
         default: tap_d = T_TLR;
      endcase
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tap_q <= T_TLR;
         ir_q <= 4'h0;
         irsh_q <= 4'h0;
         dr_q <= 9'h0;
         byp_q <= 1'b0;
         tdo_q <= 1'b0;
         jrx_q <= 1'b0;
         jok_q <= 1'b0;
         jtake_q <= 1'b0;
         jbyte_q <= 8'h0;
      end else begin
         jrx_q <= 1'b0;
         jtake_q <= 1'b0;
         if (!scan_ok) begin
            tap_q <= T_TLR;
            ir_q <= 4'h0;
         end else if (t_rise) begin
            tap_q <= tap_d;
            case (tap_q)
               T_TLR: ir_q <= 4'h0;
               T_CIR: irsh_q <= `PDP_IR_CAPT;
               T_SHIR: irsh_q <= {tdi_s, irsh_q[3:1]};
               T_UIR: ir_q <= irsh_q;
               T_CDR: begin
                  byp_q <= 1'b0;
                  // in transmit mode a pending byte goes out with good parity, else a forced parity error
                  if (comm && txmode_q && pend_q && !take_q) begin
                     dr_q <= {^txd_q, txd_q};
                     jtake_q <= 1'b1;
                  end else if (comm)
                     dr_q <= 9'h100;
               end
               T_SHDR: begin
                  byp_q <= tdi_s;
                  if (comm)
                     dr_q <= {tdi_s, dr_q[8:1]};
               end
               T_UDR: begin
                  if (comm) begin
                     jrx_q <= 1'b1;
                     jok_q <= ~(^dr_q);
                     jbyte_q <= dr_q[7:0];
                  end
               end
               default: ;
            endcase
         end else if (t_fall) begin
            // tdo changes on the falling tck edge
            if (tap_q == T_SHIR)
               tdo_q <= irsh_q[0];
            else if (tap_q == T_SHDR)
               tdo_q <= comm ? dr_q[0] : byp_q;
         end
      end
   end
   assign tdo = tdo_q;

   // ahb-lite slave: zero wait states, always okay
   reg aph_q, awr_q;
   reg [7:0] aad_q;
   wire ap = hsel & hready & htrans[1];
   wire wr = aph_q & awr_q;
   wire [8:0] st = {txmode_q, dev_rst_q, comm & scan_ok, col_q, brk_q, ferr_q, perr_q, reset_function_off, on};
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_q <= 1'b0;
         awr_q <= 1'b0;
         aad_q <= 8'h0;
         hrdata <= 32'h0;
         txreq_q <= 1'b0;
         scandis_q <= 1'b0;
         guard_q <= `PDP_GUARD_RST;
         txd_q <= 8'h0;
         pend_q <= 1'b0;
         rxd_q <= 8'h0;
         rxv_q <= 1'b0;
         perr_q <= 1'b0;
         ferr_q <= 1'b0;
         brk_q <= 1'b0;
         col_q <= 1'b0;
      end else begin
         aph_q <= ap;
         awr_q <= hwrite;
         aad_q <= haddr;
         // read data is prepared at the address phase
         if (ap && !hwrite) begin
            case (haddr)
               `PDP_OFS_CTRL: hrdata <= {30'h0, scandis_q, txreq_q};
               `PDP_OFS_GUARD: hrdata <= {24'h0, guard_q};
               `PDP_OFS_TXDATA: hrdata <= {23'h0, pend_q, txd_q};
               `PDP_OFS_RXDATA: hrdata <= {23'h0, rxv_q, rxd_q};
               `PDP_OFS_STATUS: hrdata <= {23'h0, st};
               default: hrdata <= 32'h0;
            endcase
         end
         if (wr && aad_q == `PDP_OFS_CTRL) begin
            txreq_q <= hwdata[`PDP_CTRL_TXREQ];
            scandis_q <= hwdata[`PDP_CTRL_SCANDIS];
         end
         if (wr && aad_q == `PDP_OFS_GUARD)
            guard_q <= hwdata[7:0];
         if (wr && aad_q == `PDP_OFS_TXDATA)
            txd_q <= hwdata[7:0];
         // sets win over clears: a txdata write over a take, hardware sets over software clears
         pend_q <= (wr && aad_q == `PDP_OFS_TXDATA) | (pend_q & ~take_q);
         if (rxld_q)
            rxd_q <= rxbyte_q;
         rxv_q <= rxld_q | (rxv_q & ~(ap && !hwrite && haddr == `PDP_OFS_RXDATA));
         perr_q <= perr_p_q | (perr_q & ~(wr && aad_q == `PDP_OFS_STATUS && hwdata[`PDP_ST_PERR]));
         ferr_q <= ferr_p_q | (ferr_q & ~(wr && aad_q == `PDP_OFS_STATUS && hwdata[`PDP_ST_FERR]));
         brk_q <= brk_p_q | (brk_q & ~(wr && aad_q == `PDP_OFS_STATUS && hwdata[`PDP_ST_BRK]));
         col_q <= col_p_q | (col_q & ~(wr && aad_q == `PDP_OFS_STATUS && hwdata[`PDP_ST_COL]));
      end
   end
endmodule

/* File: tb/pdp_chk.sv */
// assertion checker for the debug port physical layer pins
`timescale 1ns/1ps
module pdp_chk #(
   parameter INACT_CYC = 400,
   parameter RST_MIN_CYC = 5
) (
   input wire hclk,
   input wire hresetn,
   input wire hreadyout,
   input wire hresp,
   input wire debug_clock_line,
   input wire debug_data_line_in,
   input wire debug_data_line_out,
   input wire debug_data_line_oe_n,
   input wire reset_fuse_off,
   input wire reset_function_off,
   input wire port_active
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   int hi_q;
   int rise_q;
   int idle_q;
   int drv_q;
   logic clk_q;
   // run lengths on the raw pins; raw counts lead the synchronised copies, so bounds stay safe
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hi_q <= 0;
         rise_q <= 0;
         idle_q <= 0;
         drv_q <= 0;
         clk_q <= 1'b0;
      end else begin
         clk_q <= debug_clock_line;
         hi_q <= debug_data_line_in ? hi_q + 1 : 0;
         rise_q <= !debug_data_line_in ? 0 : rise_q + (debug_clock_line && !clk_q);
         idle_q <= (debug_clock_line != clk_q) ? 0 : idle_q + 1;
         drv_q <= (debug_data_line_oe_n || $changed(debug_data_line_out)) ? 0 : drv_q + 1;
      end
   end
   // receive mode right after activation: the device leaves the line alone
   sequence rx_quiet_s;
      debug_data_line_oe_n [*8];
   endsequence
   sequence became_active_s;
      $rose(port_active);
   endsequence
   ready_ok_a: assert property (hreadyout && !hresp) else $error("bus answer not zero-wait okay");
   fuse_keep_a: assert property (reset_fuse_off |-> reset_function_off)
      else $error("fuse setting lost");
   enable_time_a: assert property ($rose(reset_function_off) && !reset_fuse_off |-> hi_q >= RST_MIN_CYC)
      else $error("reset function dropped too early");
   act_clocks_a: assert property (became_active_s |-> rise_q >= 16)
      else $error("activated before sixteen clocks");
   rx_default_a: assert property (became_active_s |-> rx_quiet_s)
      else $error("driving right after activation");
   reset_off_a: assert property (port_active |-> reset_function_off)
      else $error("active with pin reset function on");
   clock_idle_a: assert property (port_active |-> idle_q <= INACT_CYC + 8)
      else $error("port kept active on a stopped clock");
   drive_pulse_a: assert property (drv_q < 12)
      else $error("driver left on over a held bit");
   change_edge_a: assert property ($changed(debug_data_line_out) |-> !debug_clock_line ||
      !$past(debug_clock_line, 1) || !$past(debug_clock_line, 2) || !$past(debug_clock_line, 4))
      else $error("data changed away from falling clock");
endmodule
bind pdp_top pdp_chk #(.INACT_CYC(INACT_CYC), .RST_MIN_CYC(RST_MIN_CYC)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .debug_clock_line(debug_clock_line), .debug_data_line_in(debug_data_line_in),
   .debug_data_line_out(debug_data_line_out), .debug_data_line_oe_n(debug_data_line_oe_n),
   .reset_fuse_off(reset_fuse_off), .reset_function_off(reset_function_off), .port_active(port_active));

/* File: tb/pdp_prog_model.sv */
// behavioural programmer: makes the debug clock and shares the data line through a bus keeper
`timescale 1ns/1ps
module pdp_prog_model (
   output logic clk_line,
   output logic data_lvl,
   input wire dev_out,
   input wire dev_oe_n
);
   localparam int HALF = 80;
   logic drv;
   logic oe;
   logic keep;
   initial begin
      clk_line = 1'b0;
      drv = 1'b0;
      oe = 1'b1;
      keep = 1'b0;
   end
   // programmer wins a contention, so the device sees its held bit overridden
   always @* begin
      if (oe) data_lvl = drv;
      else if (!dev_oe_n) data_lvl = dev_out;
      else data_lvl = keep;
   end
   // keeper holds the last level once both sides let go
   always @(data_lvl) keep <= data_lvl;
   // one driven bit, changed at the falling edge
   task automatic put(input logic b);
      clk_line = 1'b0;
      drv = b;
      oe = 1'b1;
      #HALF clk_line = 1'b1;
      #HALF;
   endtask
   // one released bit, taken while the clock is high
   task automatic get(output logic b);
      oe = 1'b0;
      clk_line = 1'b0;
      #HALF clk_line = 1'b1;
      #(HALF / 2) b = data_lvl;
      #(HALF / 2);
   endtask
   task automatic enable();
      drv = 1'b1;
      #400;
      repeat (16) put(1'b1);
   endtask
   // leading idle bit, start, data lsb first, parity, two stops, trailing idle
   task automatic frame(input logic [7:0] d, input logic pflip, input logic slow);
      logic [14:0] f;
      f = {2'b11, 1'b1, ~slow, ^d ^ pflip, d, 1'b0, 1'b1};
      for (int i = 0; i < 15; i++) put(f[i]);
   endtask
   task automatic brk();
      repeat (13) put(1'b0);
      repeat (2) put(1'b1);
   endtask
   task automatic recv(output logic [7:0] d, output int idle, output logic p, output logic [1:0] sp);
      logic b;
      idle = 0;
      get(b);
      while (b && idle < 300) begin
         idle++;
         get(b);
      end
      for (int i = 0; i < 8; i++) get(d[i]);
      get(p);
      get(sp[0]);
      get(sp[1]);
   endtask
endmodule

/* File: tb/prog_debug_physical_layer_test.sv */
// self-checking bench: registers, frames both ways, collision, break and clock timeout
`timescale 1ns/1ps
`include "pdp_defs.vh"
module prog_debug_physical_layer_test;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'b00;
   logic [31:0] hwdata = 32'h0;
   logic tck = 1'b0, tms = 1'b0, tdi = 1'b0, sfuse = 1'b0;
   logic [8:0] sh;
   // tap walk: comm instruction, then 0x3c with even parity through the 9-bit register
   localparam logic [23:0] TMS_SEQ = 24'h600706;
   localparam logic [23:0] TDI_SEQ = 24'h0780e0;
   logic [31:0] rd;
   logic [31:0] hrdata;
   wire hreadyout, hresp, clk_line, dl, dout, doe_n, rfo, act, drh, tdo;
   int err_count = 0;
   int samples_checked = 0;
   int idle;
   logic [7:0] byt;
   logic p;
   logic [1:0] sp;
   always #10 hclk = ~hclk;
   pdp_top #(.ACT_WIN_CYC(50), .INACT_CYC(400), .RST_MIN_CYC(5)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .debug_clock_line(clk_line), .debug_data_line_in(dl), .debug_data_line_out(dout),
      .debug_data_line_oe_n(doe_n), .reset_fuse_off(1'b0), .scan_port_enable_fuse(sfuse),
      .reset_function_off(rfo), .device_reset_hold(drh), .port_active(act), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo));
   pdp_prog_model u_prog (.clk_line(clk_line), .data_lvl(dl), .dev_out(dout), .dev_oe_n(doe_n));
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] got);
      samples_checked++;
      if (got !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", w, e, got);
      end
   endtask
   // single word; address and data phases each held until hready is seen high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(w, e, rd & m);
   endtask
   // one tck period: change on the fall, take tdo just before the rise
   task automatic tap(input logic m, input logic i, output logic o);
      tck <= 1'b0;
      tms <= m;
      tdi <= i;
      repeat (4) @(posedge hclk);
      o = tdo;
      tck <= 1'b1;
      repeat (4) @(posedge hclk);
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // a hang is cut off well past the expected run of some 40 us
   initial begin
      #1000000;
      err_count++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rdc("guard", `PDP_OFS_GUARD, 32'hff, {24'h0, `PDP_GUARD_RST});
      rdc("unmapped", 8'h1c, 32'hffffffff, 32'h0);
      rdc("status", `PDP_OFS_STATUS, 32'h1ff, 32'h0);
      $display("test reset done");
      u_prog.enable();
      repeat (6) @(posedge hclk);
      chk("enabled", 32'h3, {29'h0, drh, rfo, act});
      $display("test enable done");
      u_prog.frame(8'ha5, 1'b0, 1'b0);
      rdc("rx byte", `PDP_OFS_RXDATA, 32'h1ff, 32'h1a5);
      // bad parity, low first stop bit, then a break; none may deliver a byte
      for (int k = 0; k < 3; k++) begin
         if (k == 2) u_prog.brk();
         else u_prog.frame(8'h3c, k == 0, k == 1);
         rdc("error flag", `PDP_OFS_STATUS, 32'h4 << k, 32'h4 << k);
         rdc("rx valid", `PDP_OFS_RXDATA, 32'h100, 32'h0);
         wr(`PDP_OFS_STATUS, 32'h3c);
      end
      rdc("flags cleared", `PDP_OFS_STATUS, 32'h3c, 32'h0);
      $display("test receive done");
      // guard below the floor, then a set guard; byte, parity and stops seen on the wire
      for (int k = 0; k < 2; k++) begin
         wr(`PDP_OFS_GUARD, k ? 32'h5 : 32'h0);
         wr(`PDP_OFS_TXDATA, k ? 32'h5e : 32'h81);
         wr(`PDP_OFS_CTRL, 32'h1);
         u_prog.recv(byt, idle, p, sp);
         chk("guard idle", 32'h1, (idle >= (k ? 5 : 2)) && (idle <= (k ? 8 : 5)));
         chk("tx frame", k ? 32'h2f7 : 32'h40b, {byt, p, sp});
         u_prog.get(p);
         chk("fill bit", 32'h1, p);
         wr(`PDP_OFS_CTRL, 32'h0);
         // the turn back to receive needs one falling debug clock edge
         u_prog.get(p);
         rdc("rx mode", `PDP_OFS_STATUS, 32'h100, 32'h0);
      end
      $display("test transmit done");
      wr(`PDP_OFS_CTRL, 32'h1);
      u_prog.brk();
      wr(`PDP_OFS_CTRL, 32'h0);
      rdc("collision", `PDP_OFS_STATUS, 32'h120, 32'h020);
      chk("driver off", 32'h1, doe_n);
      u_prog.brk();
      rdc("break", `PDP_OFS_STATUS, 32'h10, 32'h10);
      wr(`PDP_OFS_STATUS, 32'h3c);
      $display("test collision done");
      repeat (450) @(posedge hclk);
      chk("timed out", 32'h0, {30'h0, rfo, act});
      $display("test timeout done");
      // scan path works with the two-wire side off; receive mode shifts out the empty frame
      sfuse <= 1'b1;
      for (int k = 0; k < 24; k++) begin
         tap(TMS_SEQ[k], TDI_SEQ[k], p);
         if (k > 12 && k < 22) sh = {p, sh[8:1]};
      end
      chk("scan out", 32'h100, {23'h0, sh});
      rdc("scan byte", `PDP_OFS_RXDATA, 32'h1ff, 32'h13c);
      rdc("comm", `PDP_OFS_STATUS, 32'h40, 32'h40);
      wr(`PDP_OFS_CTRL, 32'h2);
      rdc("scan off", `PDP_OFS_STATUS, 32'h40, 32'h0);
      $display("test scan done");
      summarize();
   end
endmodule
